// ### core/phy_access_regs.svh
// Register offsets, field positions, reset values and timing counts of the PHY indirect engine.
`ifndef PHY_ACCESS_REGS_SVH
`define PHY_ACCESS_REGS_SVH

// ==========================================================================
// Register offsets
// ==========================================================================
`define PIE_ADDR_W 10
`define PIE_OFF_DATA 10'h0a4
`define PIE_OFF_CTRL 10'h0a8

// ==========================================================================
// Field positions
// ==========================================================================
`define PIE_CTRL_PHY_HI 15
`define PIE_CTRL_PHY_LO 11
`define PIE_CTRL_IDX_HI 10
`define PIE_CTRL_IDX_LO 6
`define PIE_CTRL_WNR 1
`define PIE_CTRL_BUSY 0
`define PIE_DATA_HI 15

// ==========================================================================
// Reset values
// ==========================================================================
`define PIE_RST_FIELD5 5'h00
`define PIE_RST_BIT 1'h0
`define PIE_RST_DATA 16'h0000
`define PIE_NO_RESPONSE 16'hffff

// ==========================================================================
// Timing
// ==========================================================================
`define PIE_CLK_PERIOD_NS 25
`define PIE_TIMEOUT_NS 25600
`define PIE_TIMEOUT_CYC (`PIE_TIMEOUT_NS / `PIE_CLK_PERIOD_NS)
`define PIE_TIMER_W 11

`endif

// ### core/phy_access_pkg.sv
// Types shared by the PHY indirect engine and its management port.
package phy_access_pkg;

  // ==========================================================================
  // Management port state
  // ==========================================================================
  typedef enum logic [0:0] {PS_IDLE, PS_WAIT} port_state_e;

  typedef struct packed {
    port_state_e state;
    logic we;
    logic [4:0] phy_addr;
    logic [4:0] reg_idx;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [10:0] timer;
    logic done;
  } port_s;

  // ==========================================================================
  // Engine register state
  // ==========================================================================
  typedef struct packed {
    logic [4:0] phy_addr;
    logic [4:0] reg_idx;
    logic wnr;
    logic busy;
    logic skip;
    logic [15:0] data_wr;
    logic [15:0] data_rd;
    logic [31:0] rdata;
    logic rvalid;
  } engine_s;

endpackage

// ### core/phy_mgmt_port.sv
// Request and answer port toward the internal PHY management register sets.
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_regs.svh"

module phy_mgmt_port (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Engine side
  input wire logic i_start,
  input wire logic i_we,
  input wire logic [4:0] i_phy_addr,
  input wire logic [4:0] i_reg_idx,
  input wire logic [15:0] i_wdata,
  output logic o_done,
  output logic [15:0] o_rdata,
  // PHY side
  output logic o_req,
  output logic o_we,
  output logic [4:0] o_phy_addr,
  output logic [4:0] o_reg_idx,
  output logic [15:0] o_wdata,
  input wire logic i_ack,
  input wire logic [15:0] i_rdata
);
  import phy_access_pkg::*;

  port_s q;
  port_s d;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // A PHY that never answers would hold the busy flag forever and lock out
  // software, so a timeout ends the access and returns all ones.
  always_comb begin
    d = q;
    d.done = 1'b0;
    unique case (q.state)
      PS_IDLE: begin
        if (i_start) begin
          d.state = PS_WAIT;
          d.we = i_we;
          d.phy_addr = i_phy_addr;
          d.reg_idx = i_reg_idx;
          d.wdata = i_wdata;
          d.timer = `PIE_TIMER_W'(`PIE_TIMEOUT_CYC);
        end
      end
      PS_WAIT: begin
        d.timer = q.timer - `PIE_TIMER_W'(1);
        if (i_ack) begin
          d.state = PS_IDLE;
          d.done = 1'b1;
          d.rdata = i_rdata;
        end else if (q.timer == '0) begin
          d.state = PS_IDLE;
          d.done = 1'b1;
          d.rdata = `PIE_NO_RESPONSE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_req = (q.state == PS_WAIT);
  assign o_we = q.we;
  assign o_phy_addr = q.phy_addr;
  assign o_reg_idx = q.reg_idx;
  assign o_wdata = q.wdata;
  assign o_done = q.done;
  assign o_rdata = q.rdata;

endmodule
`default_nettype wire

// ### core/phy_indirect_engine.sv
// Indirect access engine from the register port to the internal PHY management registers.
// Behaviour
// - Every accepted write of the access control register to a PHY address other than the virtual one starts one PHY access.
// - The busy bit 0 sets on that write, stays high during the access and clears itself.
// - Bits 15:11 of the access control register give the target PHY address, reset zero.
// - Bits 10:6 give the register index inside the PHY, reset zero.
// - Bit 1 set means write the data register to the PHY, clear means read into it.
// - During a PHY read the data register is not valid until busy has cleared.
// - Accesses aimed at the virtual PHY address are never passed to any PHY.
// - The data register holds a 16-bit read/write value in bits 15:0, reset zero.
// - A data register read returns the PHY value when bit 1 is clear, else the last write.
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_regs.svh"

module phy_indirect_engine (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [`PIE_ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [31:0] i_reg_wdata,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Virtual PHY address strap
  input wire logic [4:0] i_vphy_addr,
  // Status
  output logic o_busy,
  // PHY management port
  output logic o_mgmt_req,
  output logic o_mgmt_we,
  output logic [4:0] o_mgmt_phy_addr,
  output logic [4:0] o_mgmt_reg_idx,
  output logic [15:0] o_mgmt_wdata,
  input wire logic i_mgmt_ack,
  input wire logic [15:0] i_mgmt_rdata
);
  import phy_access_pkg::*;

  engine_s q;
  engine_s d;
  logic wr_ctrl;
  logic wr_data;
  logic start;
  logic port_done;
  logic [15:0] port_rdata;
  logic done;
  logic [4:0] new_phy;

  assign wr_ctrl = i_reg_wr && (i_reg_addr == `PIE_OFF_CTRL);
  assign wr_data = i_reg_wr && (i_reg_addr == `PIE_OFF_DATA);
  assign new_phy = i_reg_wdata[`PIE_CTRL_PHY_HI:`PIE_CTRL_PHY_LO];
  // An access to the virtual PHY ends one cycle after it starts with no PHY
  // cycle at all, so software never hangs on an address nobody answers.
  assign done = q.busy && (q.skip || port_done);

  // ==========================================================================
  // Register file and access sequencing
  // ==========================================================================
  // Writes while busy are dropped: the access in flight already latched its
  // fields, and letting a write through would corrupt the data it returns.
  always_comb begin
    d = q;
    d.rvalid = 1'b0;
    start = 1'b0;
    if (wr_ctrl && !q.busy) begin
      d.phy_addr = new_phy;
      d.reg_idx = i_reg_wdata[`PIE_CTRL_IDX_HI:`PIE_CTRL_IDX_LO];
      d.wnr = i_reg_wdata[`PIE_CTRL_WNR];
      d.busy = 1'b1;
      d.skip = (new_phy == i_vphy_addr);
      start = !d.skip;
    end
    if (wr_data && !q.busy) begin
      d.data_wr = i_reg_wdata[`PIE_DATA_HI:0];
    end
    if (done) begin
      d.busy = 1'b0;
      d.skip = 1'b0;
      if (!q.wnr) begin
        d.data_rd = q.skip ? `PIE_NO_RESPONSE : port_rdata;
      end
    end
    if (i_reg_rd) begin
      d.rvalid = 1'b1;
      d.rdata = 32'h0000_0000;
      if (i_reg_addr == `PIE_OFF_DATA) begin
        d.rdata[`PIE_DATA_HI:0] = q.wnr ? q.data_wr : q.data_rd;
      end else if (i_reg_addr == `PIE_OFF_CTRL) begin
        d.rdata[`PIE_CTRL_PHY_HI:`PIE_CTRL_PHY_LO] = q.phy_addr;
        d.rdata[`PIE_CTRL_IDX_HI:`PIE_CTRL_IDX_LO] = q.reg_idx;
        d.rdata[`PIE_CTRL_WNR] = q.wnr;
        d.rdata[`PIE_CTRL_BUSY] = q.busy;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q.phy_addr <= `PIE_RST_FIELD5;
      q.reg_idx <= `PIE_RST_FIELD5;
      q.wnr <= `PIE_RST_BIT;
      q.busy <= `PIE_RST_BIT;
      q.skip <= 1'b0;
      q.data_wr <= `PIE_RST_DATA;
      q.data_rd <= `PIE_RST_DATA;
      q.rdata <= 32'h0000_0000;
      q.rvalid <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_reg_rvalid = q.rvalid;
  assign o_busy = q.busy;

  // ==========================================================================
  // PHY management port
  // ==========================================================================
  // The port takes the fields straight from the write so the PHY cycle can
  // begin the cycle after the access control write.
  phy_mgmt_port u_port (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(start),
    .i_we(i_reg_wdata[`PIE_CTRL_WNR]),
    .i_phy_addr(new_phy),
    .i_reg_idx(i_reg_wdata[`PIE_CTRL_IDX_HI:`PIE_CTRL_IDX_LO]),
    .i_wdata(q.data_wr),
    .o_done(port_done),
    .o_rdata(port_rdata),
    .o_req(o_mgmt_req),
    .o_we(o_mgmt_we),
    .o_phy_addr(o_mgmt_phy_addr),
    .o_reg_idx(o_mgmt_reg_idx),
    .o_wdata(o_mgmt_wdata),
    .i_ack(i_mgmt_ack),
    .i_rdata(i_mgmt_rdata)
  );

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_accept;
    wr_ctrl && !q.busy;
  endsequence

  sequence s_issue;
    o_mgmt_req && q.busy;
  endsequence

  property p_start;
    @(posedge i_clk) disable iff (i_rst)
    (s_accept and (new_phy != i_vphy_addr)) |=> s_issue;
  endproperty
  a_start: assert property (p_start) else $error("accepted write did not start access");

  property p_busy_set;
    @(posedge i_clk) disable iff (i_rst)
    s_accept |=> o_busy;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by write");

  property p_busy_hold;
    @(posedge i_clk) disable iff (i_rst)
    o_busy && !done |=> o_busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

  property p_busy_clear;
    @(posedge i_clk) disable iff (i_rst)
    done |=> !o_busy;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");

  property p_phy_addr;
    @(posedge i_clk) disable iff (i_rst)
    o_mgmt_req |-> o_mgmt_phy_addr == q.phy_addr;
  endproperty
  a_phy_addr: assert property (p_phy_addr) else $error("wrong PHY address");

  property p_reg_idx;
    @(posedge i_clk) disable iff (i_rst)
    o_mgmt_req |-> o_mgmt_reg_idx == q.reg_idx;
  endproperty
  a_reg_idx: assert property (p_reg_idx) else $error("wrong register index");

  property p_dir;
    @(posedge i_clk) disable iff (i_rst)
    o_mgmt_req |-> (o_mgmt_we == q.wnr) && (!q.wnr || o_mgmt_wdata == q.data_wr);
  endproperty
  a_dir: assert property (p_dir) else $error("wrong direction or write data");

  property p_no_vphy;
    @(posedge i_clk) disable iff (i_rst)
    (s_accept and (new_phy == i_vphy_addr)) |=> !o_mgmt_req [*2];
  endproperty
  a_no_vphy: assert property (p_no_vphy) else $error("virtual PHY access issued");

  property p_data_wr;
    @(posedge i_clk) disable iff (i_rst)
    wr_data && !q.busy |=> q.data_wr == $past(i_reg_wdata[15:0]);
  endproperty
  a_data_wr: assert property (p_data_wr) else $error("data write not stored");

  property p_rd_mux;
    @(posedge i_clk) disable iff (i_rst)
    i_reg_rd && (i_reg_addr == `PIE_OFF_DATA) |=>
      o_reg_rvalid && (o_reg_rdata == {16'h0000, $past(q.wnr) ? $past(q.data_wr) : $past(q.data_rd)});
  endproperty
  a_rd_mux: assert property (p_rd_mux) else $error("data read returned wrong value");

  property p_capture;
    @(posedge i_clk) disable iff (i_rst)
    port_done && q.busy && !q.wnr |=> !o_busy && (q.data_rd == $past(port_rdata));
  endproperty
  a_capture: assert property (p_capture) else $error("read data not captured");

endmodule
`default_nettype wire

// ### tb/phy_model.sv
// Behavioural model of the internal PHY management register sets.
`timescale 1ns/1ps
`default_nettype none

module phy_model (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Request side
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [4:0] i_phy_addr,
  input wire logic [4:0] i_reg_idx,
  input wire logic [15:0] i_wdata,
  output logic o_ack,
  output logic [15:0] o_rdata,
  // Test controls
  input wire logic [7:0] i_delay,
  input wire logic i_mute
);
  logic [15:0] mem [0:1023];
  logic [7:0] cnt_q;
  logic done_q;
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'ha000 | 16'(i);
    end
  end
  // Read data toggles outside an answer so that a stale sample never looks right.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_rdata <= 16'h5a5a;
      cnt_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (!i_req) begin
        cnt_q <= 8'h00;
        done_q <= 1'b0;
      end else if (!done_q && !i_mute) begin
        if (cnt_q >= i_delay) begin
          o_ack <= 1'b1;
          done_q <= 1'b1;
          if (i_we) begin
            mem[{i_phy_addr, i_reg_idx}] <= i_wdata;
          end else begin
            o_rdata <= mem[{i_phy_addr, i_reg_idx}];
          end
        end else begin
          cnt_q <= cnt_q + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/phy_indirect_engine_tb.sv
// Self-checking bench for the PHY indirect engine.
`timescale 1ns/1ps
`default_nettype none
`include "phy_access_regs.svh"

module phy_indirect_engine_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [`PIE_ADDR_W-1:0] i_reg_addr = '0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] i_reg_wdata = '0;
  logic [31:0] o_reg_rdata;
  logic o_reg_rvalid, o_busy, req, we, ack, req_q;
  logic [4:0] pa, ri, p, x;
  logic [15:0] wd, rdat, d;
  logic [7:0] dly = 8'h00;
  logic mute = 1'b0;
  int fails = 0;
  int cmp_count = 0;
  int reqs = 0;
  localparam logic [4:0] VPHY = 5'h10;
  localparam logic [9:0] CT = `PIE_OFF_CTRL;
  localparam logic [9:0] DT = `PIE_OFF_DATA;
  always #12.5 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    if (req === 1'b1 && req_q !== 1'b1) reqs++;
    req_q = req;
  end

  phy_indirect_engine u_phy_indirect_engine (.i_clk(i_clk), .i_rst(i_rst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_vphy_addr(VPHY), .o_busy(o_busy), .o_mgmt_req(req), .o_mgmt_we(we),
    .o_mgmt_phy_addr(pa), .o_mgmt_reg_idx(ri), .o_mgmt_wdata(wd),
    .i_mgmt_ack(ack), .i_mgmt_rdata(rdat));
  phy_model u_phy_model (.i_clk(i_clk), .i_rst(i_rst), .i_req(req), .i_we(we),
    .i_phy_addr(pa), .i_reg_idx(ri), .i_wdata(wd), .o_ack(ack), .o_rdata(rdat),
    .i_delay(dly), .i_mute(mute));

  // ==========================================================================
  // Access tasks
  // ==========================================================================
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_reg_wr <= 1'b1;
    i_reg_addr <= a;
    i_reg_wdata <= v;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_reg_rd <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1;
    chk({31'h0, o_reg_rvalid}, 32'h1);
    v = o_reg_rdata;
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic idle();
    logic [31:0] s;
    for (int i = 0; i < 1500; i++) begin
      rd(CT, s);
      if (s[0] === 1'b0) return;
    end
    fails++;
    report_and_stop();
  endtask
  function automatic logic [31:0] cw(input logic [4:0] pp, xx, input logic w);
    return {16'h0, pp, xx, 4'h0, w, 1'b0};
  endfunction
  task automatic xfer(input logic [4:0] pp, xx, input logic w, input logic [15:0] v);
    wr(CT, cw(pp, xx, w));
    chk({31'h0, o_busy}, 32'h1);
    chk({20'h0, req, we, pa, ri}, {20'h0, 1'b1, w, pp, xx});
    if (w) chk({16'h0, wd}, {16'h0, v});
    idle();
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rdchk(CT, 32'h0);
    rdchk(DT, 32'h0);
    rdchk(10'h0a0, 32'h0);
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 5'h01 : ((k == 1) ? 5'h1f : 5'h00);
      x = (k == 0) ? 5'h00 : 5'h1f;
      d = {p, x, 6'h15} ^ 16'hc3a5;
      dly <= 8'(k * 9);
      xfer(p, x, 1'b0, 16'h0);
      rdchk(DT, {16'h0, 16'ha000 | {6'h0, p, x}});
      wr(DT, {16'hffff, d});
      xfer(p, x, 1'b1, d);
      rdchk(DT, {16'h0, d});
      rdchk(CT, cw(p, x, 1'b1));
      xfer(p, x, 1'b0, 16'h0);
      rdchk(DT, {16'h0, d});
    end
    chk(32'(reqs), 32'd9);
    // Writes landing while busy must be dropped, not start a second access.
    dly <= 8'd40;
    wr(CT, cw(5'h02, 5'h05, 1'b0));
    wr(DT, 32'hbeef);
    wr(CT, cw(5'h07, 5'h07, 1'b1));
    idle();
    rdchk(CT, cw(5'h02, 5'h05, 1'b0));
    rdchk(DT, 32'ha045);
    chk(32'(reqs), 32'd10);
    wr(CT, cw(VPHY, 5'h03, 1'b0));
    chk({31'h0, o_busy}, 32'h1);
    chk({31'h0, req}, 32'h0);
    @(posedge i_clk);
    #1;
    chk({31'h0, o_busy}, 32'h0);
    rdchk(DT, 32'hffff);
    chk(32'(reqs), 32'd10);
    // The data write dropped while busy must not have replaced the stored value.
    xfer(5'h02, 5'h05, 1'b1, d);
    rdchk(DT, {16'h0, d});
    mute <= 1'b1;
    xfer(5'h01, 5'h02, 1'b0, 16'h0);
    rdchk(DT, 32'hffff);
    report_and_stop();
  end
endmodule
`default_nettype wire
